// >>> src/bpo_port.sv
// Bidirectional general-purpose port with bus and PWM pin overrides.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
module bpo_port
  import bpo_pkg::*;
#(
  parameter int WIDTH = WIDTH_FULL,
  parameter bit EXT_MEM_PRESENT = 1'b1,
  parameter bit PAR_SLAVE_PRESENT = 1'b1,
  parameter bit CAPCOMP_PRESENT = 1'b0
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic [WIDTH-1:0] I_PIN_IN,
  output logic [WIDTH-1:0] O_PIN_OUT,
  output logic [WIDTH-1:0] O_PIN_OE,
  output logic [WIDTH-1:0] O_PULLUP_EN,
  input wire logic [WIDTH-1:0] I_MEM_AD_OUT,
  input wire logic I_MEM_AD_OE,
  output logic [WIDTH-1:0] O_MEM_AD_IN,
  output logic O_MEM_ACTIVE,
  input wire logic I_PAR_RD_OE,
  output logic [WIDTH-1:0] O_PAR_WR_DATA,
  output logic O_PAR_ACTIVE,
  input wire logic [2:0] I_EPWM_EN,
  input wire logic [2:0] I_EPWM_OUT,
  input wire logic [2:0] I_EPWM_SHUT,
  input wire logic [2:1] I_CC_EN,
  input wire logic [2:1] I_CC_OUT,
  output logic [2:1] O_CC_CAPTURE
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] lat;
    logic [7:0] dir;
    logic ext_bus_disable;
    logic pspm;
    logic [7:0] porta;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] pout;
    logic [7:0] poe;
    logic [7:0] pull;
    logic [7:0] memin;
    logic [7:0] parwr;
    logic [2:1] capt;
  } bpo_state_t;

  bpo_state_t st;
  bpo_state_t next_st;

  localparam bpo_state_t RST_STATE = '{
    ack: 1'b0, rdata: 32'h0000_0000, lat: RST_OUT_LATCH,
    dir: RST_DIRECTION, ext_bus_disable: RST_EXT_BUS_DISABLE,
    pspm: RST_PAR_SLAVE_ENABLE, porta: RST_PORTA_LATCH,
    s1: 8'h00, s2: 8'h00, pout: 8'h00, poe: 8'h00, pull: 8'h00,
    memin: 8'h00, parwr: 8'h00, capt: 2'b00};

  // Elaboration-time checks: the logic serves only the two port widths.
  if (WIDTH != WIDTH_SMALL && WIDTH != WIDTH_FULL) begin : g_bad_width
    $error("bpo_port: WIDTH must be 3 or 8");
  end
  if (WIDTH != WIDTH_FULL && (EXT_MEM_PRESENT || PAR_SLAVE_PRESENT))
  begin : g_bad_modes
    $error("bpo_port: bus modes need the full 8-bit port");
  end

  logic [7:0] pin_ext;
  logic [7:0] mem_out_ext;
  logic mem_en;
  logic par_on;
  logic req;
  logic [7:0] wbyte;
  logic wr_ok;
  // Alternate-function inputs widened to a full byte, so that the per-pin
  // loop below never selects outside a port's declared range.
  logic [7:0] epwm_en_ext;
  logic [7:0] epwm_out_ext;
  logic [7:0] epwm_shut_ext;
  logic [7:0] cc_en_ext;
  logic [7:0] cc_out_ext;

  always_comb begin
    pin_ext = 8'h00;
    mem_out_ext = 8'h00;
    pin_ext[WIDTH-1:0] = I_PIN_IN;
    mem_out_ext[WIDTH-1:0] = I_MEM_AD_OUT;
    epwm_en_ext = {5'h00, I_EPWM_EN};
    epwm_out_ext = {5'h00, I_EPWM_OUT};
    epwm_shut_ext = {5'h00, I_EPWM_SHUT};
    cc_en_ext = {5'h00, I_CC_EN, 1'b0};
    cc_out_ext = {5'h00, I_CC_OUT, 1'b0};
  end

  // Clearing the disable bit hands the whole byte to the memory bus.
  assign mem_en = EXT_MEM_PRESENT && !st.ext_bus_disable;
  // The memory interface wins over the parallel slave mode.
  assign par_on = PAR_SLAVE_PRESENT && st.pspm && !mem_en;
  assign req = I_AVS_READ || I_AVS_WRITE;
  assign wbyte = I_AVS_WRITEDATA[7:0];
  // A write lands at the edge where the master sees waitrequest low.
  assign wr_ok = I_AVS_WRITE && st.ack && I_AVS_BYTEENABLE[0];

  always_comb begin
    logic [31:0] rd;
    logic lo;
    logic le;
    rd = 32'h0000_0000;
    lo = 1'b0;
    le = 1'b0;
    next_st = st;
    // One wait cycle per access keeps read data registered.
    next_st.ack = req && !st.ack;
    next_st.s1 = pin_ext;
    next_st.s2 = st.s1;
    case (I_AVS_ADDRESS)
      OFF_PIN_LEVELS: rd[7:0] = st.s2;
      OFF_OUT_LATCH: rd[7:0] = st.lat;
      OFF_DIRECTION: rd[7:0] = st.dir;
      OFF_MEM_CTRL: rd[BIT_EXT_BUS_DISABLE] = st.ext_bus_disable;
      OFF_PAR_CTRL: rd[BIT_PAR_SLAVE_ENABLE] = st.pspm;
      OFF_PORTA_LATCH: rd[7:0] = st.porta;
      default: rd = 32'h0000_0000;
    endcase
    if (WIDTH == WIDTH_SMALL) begin
      rd[7:WIDTH_SMALL] = (I_AVS_ADDRESS == OFF_PIN_LEVELS ||
        I_AVS_ADDRESS == OFF_OUT_LATCH || I_AVS_ADDRESS == OFF_DIRECTION) ?
        5'h00 : rd[7:WIDTH_SMALL];
    end
    if (I_AVS_READ && !st.ack) begin
      next_st.rdata = rd;
    end
    if (wr_ok) begin
      case (I_AVS_ADDRESS)
        // A write to the level register lands in the latch, as usual.
        OFF_PIN_LEVELS: next_st.lat = wbyte;
        OFF_OUT_LATCH: next_st.lat = wbyte;
        OFF_DIRECTION: next_st.dir = wbyte;
        OFF_MEM_CTRL: next_st.ext_bus_disable = wbyte[BIT_EXT_BUS_DISABLE];
        OFF_PAR_CTRL: next_st.pspm = wbyte[BIT_PAR_SLAVE_ENABLE];
        OFF_PORTA_LATCH: next_st.porta = wbyte;
        default: next_st.lat = st.lat;
      endcase
    end
    for (int i = 0; i < 8; i++) begin
      lo = st.lat[i];
      le = !st.dir[i];
      if (par_on) begin
        // Parallel data drives only while the external reader reads.
        lo = st.lat[i];
        le = I_PAR_RD_OE;
      end
      if (CAPCOMP_PRESENT && i >= 1 && i <= 2) begin
        if (cc_en_ext[i] && !st.dir[i] && !par_on) begin
          lo = cc_out_ext[i];
          le = 1'b1;
        end
      end
      if (CAPCOMP_PRESENT && i <= 2) begin
        if (epwm_en_ext[i] && !st.dir[i]) begin
          lo = epwm_out_ext[i];
          le = !epwm_shut_ext[i];
        end
      end
      if (mem_en) begin
        lo = mem_out_ext[i];
        le = I_MEM_AD_OE;
      end
      if (i >= WIDTH) begin
        lo = 1'b0;
        le = 1'b0;
      end
      next_st.pout[i] = lo;
      next_st.poe[i] = le;
      // An output pin never keeps its pull-up.
      next_st.pull[i] = st.porta[BIT_SHARED_PULLUP] && !le &&
        (i < WIDTH);
    end
    next_st.memin = mem_en ? st.s2 : 8'h00;
    // Written parallel data comes from the pins whatever the direction.
    next_st.parwr = par_on ? st.s2 : st.parwr;
    for (int j = 1; j <= 2; j++) begin
      next_st.capt[j] = CAPCOMP_PRESENT && st.dir[j] && st.s2[j];
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st <= RST_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign O_AVS_WAITREQUEST = req && !st.ack;
  assign O_AVS_READDATA = st.rdata;
  assign O_PIN_OUT = st.pout[WIDTH-1:0];
  assign O_PIN_OE = st.poe[WIDTH-1:0];
  assign O_PULLUP_EN = st.pull[WIDTH-1:0];
  assign O_MEM_AD_IN = st.memin[WIDTH-1:0];
  assign O_MEM_ACTIVE = mem_en;
  assign O_PAR_WR_DATA = st.parwr[WIDTH-1:0];
  assign O_PAR_ACTIVE = par_on;
  assign O_CC_CAPTURE = st.capt;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  a_dir_in_hiz: assert property (
    !mem_en && !par_on && st.dir[0] |=> !O_PIN_OE[0])
    else $error("input pin is driven");

  a_dir_out_latch: assert property (
    !mem_en && !par_on && !st.dir[0] && !I_EPWM_EN[0]
    |=> O_PIN_OE[0] && O_PIN_OUT[0] == $past(st.lat[0]))
    else $error("output pin does not follow latch");

  a_latch_readback: assert property (
    I_AVS_READ && !st.ack && I_AVS_ADDRESS == OFF_OUT_LATCH
    |=> !O_AVS_WAITREQUEST && O_AVS_READDATA[WIDTH-1:0] ==
    $past(st.lat[WIDTH-1:0]))
    else $error("latch read returns wrong value");

  a_reset_inputs: assert property (
    @(posedge I_CLK) $fell(I_RST) |-> O_PIN_OE == '0 &&
    O_PULLUP_EN == '0)
    else $error("pins not inputs after reset");

  a_mem_override: assert property (
    mem_en && I_MEM_AD_OE |=> O_PIN_OE == {WIDTH{1'b1}} &&
    O_PIN_OUT == $past(I_MEM_AD_OUT))
    else $error("memory bus does not own the pins");

  a_pullup_output: assert property (
    ##1 (O_PULLUP_EN & O_PIN_OE) == '0)
    else $error("pull-up on a driven pin");

  a_pullup_shared: assert property (
    !st.porta[BIT_SHARED_PULLUP] |=> O_PULLUP_EN == '0)
    else $error("pull-up without enable");

  a_par_write: assert property (
    par_on ##1 par_on |=> O_PAR_WR_DATA == $past(st.s2[WIDTH-1:0]))
    else $error("parallel write data not from pins");

  a_par_read: assert property (
    par_on && I_PAR_RD_OE && !I_EPWM_EN[0]
    |=> O_PIN_OE[0] && O_PIN_OUT[0] == $past(st.lat[0]))
    else $error("parallel read not driving latch");

  a_bus_answer: assert property (
    req && !st.ack |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST)
    else $error("bus answer not after one wait cycle");

  a_write_lands: assert property (
    I_AVS_WRITE && st.ack && I_AVS_BYTEENABLE[0] &&
    I_AVS_ADDRESS == OFF_OUT_LATCH |=> st.lat == $past(I_AVS_WRITEDATA[7:0]))
    else $error("latch write did not land");

  a_write_dropped: assert property (
    I_AVS_WRITE && !I_AVS_BYTEENABLE[0] |=> $stable(st.lat))
    else $error("disabled byte lane changed the latch");

  a_idle_no_wait: assert property (
    !I_AVS_READ && !I_AVS_WRITE |-> !O_AVS_WAITREQUEST)
    else $error("waitrequest without a request");

  a_width_upper: assert property (
    I_AVS_READ && !st.ack && I_AVS_ADDRESS == OFF_DIRECTION
    |=> O_AVS_READDATA[31:WIDTH] == '0)
    else $error("bits beyond the port width read nonzero");

  a_level_read: assert property (
    I_AVS_READ && !st.ack && I_AVS_ADDRESS == OFF_PIN_LEVELS
    |=> O_AVS_READDATA[WIDTH-1:0] == $past(st.s2[WIDTH-1:0]))
    else $error("level read is not the synchronised pin");

  a_pullup_input: assert property (
    st.porta[BIT_SHARED_PULLUP] && !mem_en && !par_on && st.dir[0]
    |=> O_PULLUP_EN[0])
    else $error("enabled pull-up missing on input pin");

  a_pullup_reset: assert property (
    @(posedge I_CLK) $fell(I_RST) |-> !st.porta[BIT_SHARED_PULLUP])
    else $error("shared pull-up enable set after reset");

  a_mem_ignores_dir: assert property (
    mem_en && !I_MEM_AD_OE |=> O_PIN_OE == '0)
    else $error("direction bits drive pins in memory mode");

  a_mem_over_par: assert property (
    mem_en |-> !O_PAR_ACTIVE && O_MEM_ACTIVE)
    else $error("parallel mode active beside memory bus");

  a_mem_first: assert property (
    mem_en && I_MEM_AD_OE && (I_PAR_RD_OE || I_EPWM_EN != '0)
    |=> O_PIN_OE == {WIDTH{1'b1}} && O_PIN_OUT == $past(I_MEM_AD_OUT))
    else $error("memory bus lost the pins");

  a_par_enable: assert property (
    st.pspm && !mem_en |-> O_PAR_ACTIVE == PAR_SLAVE_PRESENT)
    else $error("parallel mode not entered");

  a_par_idle_hiz: assert property (
    par_on && !I_PAR_RD_OE && (!CAPCOMP_PRESENT || I_EPWM_EN == '0)
    |=> O_PIN_OE == '0)
    else $error("parallel port drives without a read");

  a_no_alt_full: assert property (
    !CAPCOMP_PRESENT && !mem_en && !par_on && !st.dir[0]
    |=> O_PIN_OUT[0] == $past(st.lat[0]))
    else $error("alternate output on a package without it");

  a_pwm_ch_b: assert property (
    CAPCOMP_PRESENT && !mem_en && I_EPWM_EN[0] && !st.dir[0] &&
    !I_EPWM_SHUT[0] |=> O_PIN_OE[0] && O_PIN_OUT[0] == $past(I_EPWM_OUT[0]))
    else $error("pwm channel b does not own bit 0");

  a_pwm_shutdown: assert property (
    CAPCOMP_PRESENT && !mem_en && I_EPWM_EN[0] && !st.dir[0] &&
    I_EPWM_SHUT[0] |=> !O_PIN_OE[0])
    else $error("pwm shutdown does not release bit 0");

  a_pwm_ch_a: assert property (
    CAPCOMP_PRESENT && !mem_en && I_EPWM_EN[1] && !st.dir[1] &&
    !I_EPWM_SHUT[1] |=> O_PIN_OE[1] && O_PIN_OUT[1] == $past(I_EPWM_OUT[1]))
    else $error("pwm channel a does not own bit 1");

  a_cmp3_out: assert property (
    CAPCOMP_PRESENT && !mem_en && !par_on && I_CC_EN[1] && !I_EPWM_EN[1] &&
    !st.dir[1] |=> O_PIN_OE[1] && O_PIN_OUT[1] == $past(I_CC_OUT[1]))
    else $error("unit 3 compare does not own bit 1");

  a_cap3_in: assert property (
    st.dir[1] |=> O_CC_CAPTURE[1] == ($past(st.s2[1]) && CAPCOMP_PRESENT))
    else $error("unit 3 capture not from pin");

  a_cmp4_out: assert property (
    CAPCOMP_PRESENT && !mem_en && !par_on && I_CC_EN[2] && !I_EPWM_EN[2] &&
    !st.dir[2] |=> O_PIN_OE[2] && O_PIN_OUT[2] == $past(I_CC_OUT[2]))
    else $error("unit 4 compare does not own bit 2");

  a_cap4_in: assert property (
    st.dir[2] |=> O_CC_CAPTURE[2] == ($past(st.s2[2]) && CAPCOMP_PRESENT))
    else $error("unit 4 capture not from pin");

endmodule : bpo_port

// >>> inc/bpo_pkg.sv
// Constants shared by the bidirectional port block.
package bpo_pkg;
  localparam logic [4:0] OFF_PIN_LEVELS = 5'h00;
  localparam logic [4:0] OFF_OUT_LATCH = 5'h04;
  localparam logic [4:0] OFF_DIRECTION = 5'h08;
  localparam logic [4:0] OFF_MEM_CTRL = 5'h0c;
  localparam logic [4:0] OFF_PAR_CTRL = 5'h10;
  localparam logic [4:0] OFF_PORTA_LATCH = 5'h14;
  localparam int BIT_EXT_BUS_DISABLE = 7;
  localparam int BIT_PAR_SLAVE_ENABLE = 4;
  localparam int BIT_SHARED_PULLUP = 7;
  localparam logic [7:0] RST_OUT_LATCH = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hff;
  localparam logic RST_EXT_BUS_DISABLE = 1'b1;
  localparam logic RST_PAR_SLAVE_ENABLE = 1'b0;
  localparam logic [7:0] RST_PORTA_LATCH = 8'h00;
  localparam int WIDTH_SMALL = 3;
  localparam int WIDTH_FULL = 8;
endpackage : bpo_pkg

// >>> test/bpo_pin_model.sv
// Model of the board wiring and outside drivers on the port pins.
`timescale 1ns/10ps
module bpo_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_oe,
  input wire logic [W-1:0] i_pu,
  input wire logic [W-1:0] i_ext_en,
  input wire logic [W-1:0] i_ext_val,
  output logic [W-1:0] o_level
);
  // A pin nobody drives and nothing pulls reads the inverse of the outside
  // driver's value, so a missing drive or pull-up cannot pass by luck.
  always_comb begin
    for (int b = 0; b < W; b++) begin
      if (i_oe[b]) begin
        o_level[b] = i_out[b];
      end else if (i_ext_en[b]) begin
        o_level[b] = i_ext_val[b];
      end else if (i_pu[b]) begin
        o_level[b] = 1'b1;
      end else begin
        o_level[b] = ~i_ext_val[b];
      end
    end
  end
endmodule : bpo_pin_model

// >>> test/testbench.sv
// Self-checking bench for the bidirectional port block.
`timescale 1ns/10ps
module testbench;
  import bpo_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hf;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic [7:0] pins, pout, poe, pu, ad_in, par_wd;
  logic [7:0] ad_out = 8'h00;
  logic ad_oe = 1'b0;
  logic par_oe = 1'b0;
  logic mem_act, par_act;
  logic [2:0] pw_en = 3'h0;
  logic [2:0] pw_out = 3'h0;
  logic [2:1] cc_en = 2'h0;
  logic [2:1] cc_out = 2'h0;
  logic [2:1] cc_cap;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h5a;
  int fails = 0;
  int total_checks = 0;

  initial begin
    forever #12.5 clk = ~clk;
  end

  bpo_port dut (.I_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_BYTEENABLE(be),
    .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(waitreq), .I_PIN_IN(pins), .O_PIN_OUT(pout),
    .O_PIN_OE(poe), .O_PULLUP_EN(pu), .I_MEM_AD_OUT(ad_out),
    .I_MEM_AD_OE(ad_oe), .O_MEM_AD_IN(ad_in), .O_MEM_ACTIVE(mem_act),
    .I_PAR_RD_OE(par_oe), .O_PAR_WR_DATA(par_wd), .O_PAR_ACTIVE(par_act),
    .I_EPWM_EN(pw_en), .I_EPWM_OUT(pw_out), .I_EPWM_SHUT(3'h0),
    .I_CC_EN(cc_en), .I_CC_OUT(cc_out), .O_CC_CAPTURE(cc_cap));

  bpo_pin_model #(.W(8)) pads (.i_out(pout), .i_oe(poe), .i_pu(pu),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pins));

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Request stays up until the edge that sees waitrequest low.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      fails++;
      test_done();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rdc

  task automatic wrr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wrr

  // Covers the two synchroniser stages plus the registered pin outputs.
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask : settle

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(OFF_DIRECTION, 32'hff);
    rdc(OFF_OUT_LATCH, 32'h00);
    rdc(OFF_MEM_CTRL, 32'h80);
    rdc(OFF_PAR_CTRL, 32'h00);
    rdc(OFF_PORTA_LATCH, 32'h00);
    chk({24'h0, poe}, 32'h00);
    chk({24'h0, pu}, 32'h00);
    chk({31'h0, waitreq}, 32'h0);
    $display("test reset done");
    ext_en <= 8'h0f;
    ext_val <= 8'h3c;
    wrr(OFF_OUT_LATCH, 8'ha5);
    wrr(OFF_DIRECTION, 8'h0f);
    settle();
    chk({24'h0, poe}, 32'hf0);
    chk({24'h0, pout & poe}, 32'ha0);
    rdc(OFF_PIN_LEVELS, 32'hac);
    rdc(OFF_OUT_LATCH, 32'ha5);
    $display("test port done");
    ext_en <= 8'h00;
    wrr(OFF_PORTA_LATCH, 8'h80);
    settle();
    chk({24'h0, pu}, 32'h0f);
    rdc(OFF_PIN_LEVELS, 32'haf);
    be <= 4'h0;
    wrr(OFF_OUT_LATCH, 8'h00);
    be <= 4'hf;
    rdc(OFF_OUT_LATCH, 32'ha5);
    rdc(5'h18, 32'h00);
    $display("test pullup done");
    pw_en <= 3'h7;
    pw_out <= 3'h2;
    cc_en <= 2'h3;
    cc_out <= 2'h1;
    wrr(OFF_DIRECTION, 8'h00);
    settle();
    chk({24'h0, pout}, 32'ha5);
    chk({24'h0, pu}, 32'h00);
    chk({30'h0, cc_cap}, 32'h0);
    $display("test alternate done");
    wrr(OFF_PAR_CTRL, 8'h10);
    par_oe <= 1'b1;
    settle();
    chk({31'h0, par_act}, 32'h1);
    chk({24'h0, poe}, 32'hff);
    chk({24'h0, pout}, 32'ha5);
    par_oe <= 1'b0;
    ext_en <= 8'hff;
    ext_val <= 8'h96;
    settle();
    chk({24'h0, poe}, 32'h00);
    chk({24'h0, par_wd}, 32'h96);
    $display("test parallel done");
    ad_oe <= 1'b1;
    ad_out <= 8'h3c;
    par_oe <= 1'b1;
    ext_en <= 8'h00;
    wrr(OFF_MEM_CTRL, 8'h00);
    settle();
    chk({30'h0, mem_act, par_act}, 32'h2);
    chk({24'h0, poe}, 32'hff);
    chk({24'h0, pout}, 32'h3c);
    ad_oe <= 1'b0;
    par_oe <= 1'b0;
    ext_en <= 8'hff;
    ext_val <= 8'h69;
    settle();
    chk({24'h0, poe}, 32'h00);
    chk({24'h0, ad_in}, 32'h69);
    $display("test memory done");
    test_done();
  end
endmodule : testbench
